// file: core/gfm_pin_mux.sv
// Pin function multiplexer for the second general purpose pin, with APB registers
//
// Functional notes
// - Polarity bit 10 set inverts the pin signal; clear passes it unchanged.
// - Code 00001 drives the pin from the level bit at position 6.
// - The level bit is write only; its readback is not to be trusted.
// - Function select sits in bits 4:0, resets to zero, code 0 routes clock output.
// - Codes 02, 03, 04 route serial data, interrupt request, temperature shutdown.
// - Code 0A routes range control activity, 0B sequencer done.
// - Codes 0C to 10 route the five level control status flags.
// - Codes 11, 12, 13 route FIFO error, output clock, microphone clock.
// - Codes 15 and 16 route microphone detect and short circuit flags.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module gfm_pin_mux (
    input wire logic clock,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [gfm_pkg::ADDR_W-1:0] paddr,
    input wire logic [gfm_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic pslverr,
    output logic [gfm_pkg::DATA_W-1:0] prdata,
    // Sources
    input wire logic clockOutput,
    input wire logic serialDataOut,
    input wire logic irqRequest,
    input wire logic tempShutdown,
    input wire logic secondPllLock,
    input wire logic thirdPllLock,
    input wire logic freqLockedLoopLock,
    input wire logic rangeCtrlActivity,
    input wire logic writeSeqDone,
    input wire logic levelNoiseGate,
    input wire logic levelPeakOverload,
    input wire logic levelSaturation,
    input wire logic levelThreshold,
    input wire logic levelLock,
    input wire logic fifoError,
    input wire logic outputClock,
    input wire logic micClock,
    input wire logic micDetect,
    input wire logic micShort,
    // Pin
    output logic gpio2Pin
);

    // Control register and pin state
    logic [gfm_pkg::FN_W-1:0] functionSelect;
    logic invert;
    logic driveLevel;
    logic pinLevel;
    logic [gfm_pkg::DATA_W-1:0] readData;
    logic [gfm_pkg::FN_W-1:0] next_functionSelect;
    logic next_invert;
    logic next_driveLevel;
    logic next_pinLevel;
    logic [gfm_pkg::DATA_W-1:0] next_readData;

    // Bus decode
    logic setupPhase;
    logic accessPhase;
    logic hitCtrl;
    logic hitStatus;
    logic ctrlWrite;
    logic [31:0] sources;
    logic routed;
    logic reservedHit;

    // Zero wait states; unmapped addresses answer with an error
    always_comb begin
        setupPhase = psel && !penable;
        accessPhase = psel && penable;
        hitCtrl = (paddr == gfm_pkg::CTRL_ADDR);
        hitStatus = (paddr == gfm_pkg::STATUS_ADDR);
        pready = 1'b1;
        pslverr = accessPhase && !hitCtrl && !hitStatus;
        ctrlWrite = accessPhase && pwrite && hitCtrl;
    end

    // Source vector indexed by function code; reserved slots stay low
    always_comb begin
        sources = 32'h00000000;
        sources[gfm_pkg::GFM_FN_CLOCK_OUT] = clockOutput;
        sources[gfm_pkg::GFM_FN_LEVEL] = driveLevel;
        sources[gfm_pkg::GFM_FN_SERIAL_DATA] = serialDataOut;
        sources[gfm_pkg::GFM_FN_IRQ] = irqRequest;
        sources[gfm_pkg::GFM_FN_TEMP_SHUTDOWN] = tempShutdown;
        sources[gfm_pkg::GFM_FN_SECOND_PLL_LOCK] = secondPllLock;
        sources[gfm_pkg::GFM_FN_THIRD_PLL_LOCK] = thirdPllLock;
        sources[gfm_pkg::GFM_FN_FREQ_LOOP_LOCK] = freqLockedLoopLock;
        sources[gfm_pkg::GFM_FN_RANGE_ACTIVITY] = rangeCtrlActivity;
        sources[gfm_pkg::GFM_FN_SEQ_DONE] = writeSeqDone;
        sources[gfm_pkg::GFM_FN_NOISE_GATE] = levelNoiseGate;
        sources[gfm_pkg::GFM_FN_PEAK_OVERLOAD] = levelPeakOverload;
        sources[gfm_pkg::GFM_FN_SATURATION] = levelSaturation;
        sources[gfm_pkg::GFM_FN_LEVEL_THRESHOLD] = levelThreshold;
        sources[gfm_pkg::GFM_FN_LEVEL_LOCK] = levelLock;
        sources[gfm_pkg::GFM_FN_FIFO_ERROR] = fifoError;
        sources[gfm_pkg::GFM_FN_OUTPUT_CLOCK] = outputClock;
        sources[gfm_pkg::GFM_FN_MIC_CLOCK] = micClock;
        sources[gfm_pkg::GFM_FN_MIC_DETECT] = micDetect;
        sources[gfm_pkg::GFM_FN_MIC_SHORT] = micShort;
    end

    // Selection and polarity
    gfm_source_mux #(
        .SEL_W(gfm_pkg::FN_W)
    ) u_mux (
        .sel(functionSelect),
        .sources(sources),
        .reservedMask(gfm_pkg::RESERVED_MASK),
        .invert(invert),
        .routed(routed),
        .reservedHit(reservedHit)
    );

    // Next state: register writes, pin level, read data captured in setup
    always_comb begin
        next_functionSelect = functionSelect;
        next_invert = invert;
        next_driveLevel = driveLevel;
        next_readData = readData;
        // Low byte lane carries the select and level, next lane the polarity
        if (ctrlWrite && pstrb[0]) begin
            next_functionSelect = pwdata[gfm_pkg::FN_LSB +: gfm_pkg::FN_W];
            next_driveLevel = pwdata[gfm_pkg::LEVEL_BIT];
        end
        if (ctrlWrite && pstrb[1]) begin
            next_invert = pwdata[gfm_pkg::INVERT_BIT];
        end
        // Registered pin; sources pass with one cycle of latency
        next_pinLevel = routed;
        // Read data is ready by the access phase; level bit reads zero
        if (setupPhase && !pwrite) begin
            next_readData = 32'h00000000;
            if (hitCtrl) begin
                next_readData[gfm_pkg::FN_LSB +: gfm_pkg::FN_W] = functionSelect;
                next_readData[gfm_pkg::INVERT_BIT] = invert;
                next_readData[gfm_pkg::LEVEL_BIT] = 1'b0;
            end else if (hitStatus) begin
                next_readData[gfm_pkg::STAT_PIN_BIT] = pinLevel;
                next_readData[gfm_pkg::STAT_RSVD_BIT] = reservedHit;
            end
        end
    end

    // State registers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            functionSelect <= gfm_pkg::FN_RESET;
            invert <= gfm_pkg::INVERT_RESET;
            driveLevel <= gfm_pkg::LEVEL_RESET;
            pinLevel <= 1'b0;
            readData <= 32'h00000000;
        end else begin
            functionSelect <= next_functionSelect;
            invert <= next_invert;
            driveLevel <= next_driveLevel;
            pinLevel <= next_pinLevel;
            readData <= next_readData;
        end
    end

    // Outputs straight from flip-flops
    assign gpio2Pin = pinLevel;
    assign prdata = readData;

    // Checks on the pin path and the register file
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    // Write to the control word lands in the select field
    select_write_a: assert property (ctrlWrite && pstrb[0] |=> functionSelect == $past(pwdata[4:0]))
        else $error("function select not updated by write");

    // Write to the polarity lane lands in the invert bit
    invert_write_a: assert property (ctrlWrite && pstrb[1] |=> invert == $past(pwdata[10]))
        else $error("polarity bit not updated by write");

    // Static level reaches the pin, inverted when asked
    static_level_a: assert property (functionSelect == gfm_pkg::GFM_FN_LEVEL && !ctrlWrite |=>
        gpio2Pin == ($past(driveLevel) ^ $past(invert)))
        else $error("static level not on pin");

    // Level bit never reads back a stored value
    level_readback_a: assert property (setupPhase && !pwrite && hitCtrl |=> prdata[6] == 1'b0)
        else $error("level bit read back nonzero");

    // Clock output code routes the clock source
    clock_route_a: assert property (functionSelect == gfm_pkg::GFM_FN_CLOCK_OUT |=>
        gpio2Pin == ($past(clockOutput) ^ $past(invert)))
        else $error("clock output not routed");

    // Serial data and interrupt codes
    serial_route_a: assert property (functionSelect == gfm_pkg::GFM_FN_SERIAL_DATA |=>
        gpio2Pin == ($past(serialDataOut) ^ $past(invert)))
        else $error("serial data not routed");
    irq_route_a: assert property (functionSelect == 5'h03 && !invert |=> gpio2Pin == $past(irqRequest))
        else $error("interrupt request not routed");

    // Lock indicators
    lock_route_a: assert property (functionSelect == gfm_pkg::GFM_FN_FREQ_LOOP_LOCK && invert |=>
        gpio2Pin == !$past(freqLockedLoopLock))
        else $error("loop lock not routed inverted");

    // Sequencer done code
    seq_route_a: assert property (functionSelect == gfm_pkg::GFM_FN_SEQ_DONE |=>
        gpio2Pin == ($past(writeSeqDone) ^ $past(invert)))
        else $error("sequencer done not routed");

    // Level control saturation code
    sat_route_a: assert property (functionSelect == gfm_pkg::GFM_FN_SATURATION |=>
        gpio2Pin == ($past(levelSaturation) ^ $past(invert)))
        else $error("saturation flag not routed");

    // FIFO error code
    fifo_route_a: assert property (functionSelect == gfm_pkg::GFM_FN_FIFO_ERROR |=>
        gpio2Pin == ($past(fifoError) ^ $past(invert)))
        else $error("FIFO error not routed");

    // Microphone short circuit code
    mic_route_a: assert property (functionSelect == gfm_pkg::GFM_FN_MIC_SHORT |=>
        gpio2Pin == ($past(micShort) ^ $past(invert)))
        else $error("mic short flag not routed");

    // Temperature shutdown code
    temp_route_a: assert property (functionSelect == gfm_pkg::GFM_FN_TEMP_SHUTDOWN |=>
        gpio2Pin == ($past(tempShutdown) ^ $past(invert)))
        else $error("temperature shutdown not routed");

    // Second loop lock code
    second_lock_a: assert property (functionSelect == gfm_pkg::GFM_FN_SECOND_PLL_LOCK |=>
        gpio2Pin == ($past(secondPllLock) ^ $past(invert)))
        else $error("second lock not routed");

    // Third loop lock code
    third_lock_a: assert property (functionSelect == gfm_pkg::GFM_FN_THIRD_PLL_LOCK |=>
        gpio2Pin == ($past(thirdPllLock) ^ $past(invert)))
        else $error("third lock not routed");

    // Range control activity code
    range_route_a: assert property (functionSelect == gfm_pkg::GFM_FN_RANGE_ACTIVITY |=>
        gpio2Pin == ($past(rangeCtrlActivity) ^ $past(invert)))
        else $error("range activity not routed");

    // Noise gate code
    gate_route_a: assert property (functionSelect == gfm_pkg::GFM_FN_NOISE_GATE |=>
        gpio2Pin == ($past(levelNoiseGate) ^ $past(invert)))
        else $error("noise gate flag not routed");

    // Peak overload code
    peak_route_a: assert property (functionSelect == gfm_pkg::GFM_FN_PEAK_OVERLOAD |=>
        gpio2Pin == ($past(levelPeakOverload) ^ $past(invert)))
        else $error("peak overload not routed");

    // Level threshold code
    threshold_route_a: assert property (functionSelect == gfm_pkg::GFM_FN_LEVEL_THRESHOLD |=>
        gpio2Pin == ($past(levelThreshold) ^ $past(invert)))
        else $error("level threshold not routed");

    // Level lock code
    level_lock_a: assert property (functionSelect == gfm_pkg::GFM_FN_LEVEL_LOCK |=>
        gpio2Pin == ($past(levelLock) ^ $past(invert)))
        else $error("level lock not routed");

    // Output clock code; fast clocks alias through the pin flop
    out_clock_a: assert property (functionSelect == gfm_pkg::GFM_FN_OUTPUT_CLOCK |=>
        gpio2Pin == ($past(outputClock) ^ $past(invert)))
        else $error("output clock not routed");

    // Microphone clock code
    mic_clock_a: assert property (functionSelect == gfm_pkg::GFM_FN_MIC_CLOCK |=>
        gpio2Pin == ($past(micClock) ^ $past(invert)))
        else $error("mic clock not routed");

    // Microphone detect code
    mic_detect_a: assert property (functionSelect == gfm_pkg::GFM_FN_MIC_DETECT |=>
        gpio2Pin == ($past(micDetect) ^ $past(invert)))
        else $error("mic detect flag not routed");

    // Status word holds the pin and reserved flag seen in the setup cycle
    status_read_a: assert property (setupPhase && !pwrite && hitStatus |=>
        prdata == {30'h00000000, $past(reservedHit), $past(gpio2Pin)})
        else $error("status word wrong");

    // Mapped places never answer with an error
    mapped_ok_a: assert property (accessPhase && (hitCtrl || hitStatus) |-> !pslverr)
        else $error("mapped access flagged as error");

    // Reserved codes hold the pin at the polarity level only
    reserved_pin_a: assert property (reservedHit |=> gpio2Pin == $past(invert))
        else $error("reserved code drove a source");

    // Unmapped access answers with an error in the same access cycle
    unmapped_err_a: assert property (accessPhase && !hitCtrl && !hitStatus |-> pslverr && pready)
        else $error("unmapped access without error");

    // Main scenarios
    cover_level_c: cover property (ctrlWrite ##1 functionSelect == 5'h01 ##1 gpio2Pin);
    cover_invert_c: cover property (invert && functionSelect == 5'h06 ##1 !gpio2Pin);
    cover_status_c: cover property (setupPhase && hitStatus && !pwrite ##1 accessPhase);
    cover_reserved_c: cover property (reservedHit);

endmodule

// file: core/gfm_source_mux.sv
// Selector: picks one source by function code and applies polarity
`timescale 1ns/1ps
module gfm_source_mux #(
    parameter int SEL_W = 5
) (
    input wire logic [SEL_W-1:0] sel,
    input wire logic [(1<<SEL_W)-1:0] sources,
    input wire logic [(1<<SEL_W)-1:0] reservedMask,
    input wire logic invert,
    output logic routed,
    output logic reservedHit
);

    logic picked;

    // Reserved slots give a quiet low before inversion
    always_comb begin
        reservedHit = reservedMask[sel];
        picked = reservedHit ? 1'b0 : sources[sel];
        // Inversion sits after selection so it covers every source
        routed = picked ^ invert;
    end

endmodule

// file: pkg/gfm_pkg.sv
// Package: register map, field layout and function codes of the pin multiplexer
package gfm_pkg;

    // Bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;

    // Register indices; byte address is four times the index
    localparam logic [ADDR_W-1:0] CTRL_INDEX = 12'h201;
    localparam logic [ADDR_W-1:0] STATUS_INDEX = 12'h2F0;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 12'h804;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'hBC0;

    // Control register field positions
    localparam int INVERT_BIT = 10;
    localparam int LEVEL_BIT = 6;
    localparam int FN_LSB = 0;
    localparam int FN_W = 5;

    // Status register field positions
    localparam int STAT_PIN_BIT = 0;
    localparam int STAT_RSVD_BIT = 1;

    // Reset values
    localparam logic [FN_W-1:0] FN_RESET = 5'h00;
    localparam logic INVERT_RESET = 1'b0;
    localparam logic LEVEL_RESET = 1'b0;

    // Function select codes
    typedef enum logic [FN_W-1:0] {
        GFM_FN_CLOCK_OUT = 5'h00,
        GFM_FN_LEVEL = 5'h01,
        GFM_FN_SERIAL_DATA = 5'h02,
        GFM_FN_IRQ = 5'h03,
        GFM_FN_TEMP_SHUTDOWN = 5'h04,
        GFM_FN_SECOND_PLL_LOCK = 5'h06,
        GFM_FN_THIRD_PLL_LOCK = 5'h07,
        GFM_FN_FREQ_LOOP_LOCK = 5'h09,
        GFM_FN_RANGE_ACTIVITY = 5'h0A,
        GFM_FN_SEQ_DONE = 5'h0B,
        GFM_FN_NOISE_GATE = 5'h0C,
        GFM_FN_PEAK_OVERLOAD = 5'h0D,
        GFM_FN_SATURATION = 5'h0E,
        GFM_FN_LEVEL_THRESHOLD = 5'h0F,
        GFM_FN_LEVEL_LOCK = 5'h10,
        GFM_FN_FIFO_ERROR = 5'h11,
        GFM_FN_OUTPUT_CLOCK = 5'h12,
        GFM_FN_MIC_CLOCK = 5'h13,
        GFM_FN_MIC_DETECT = 5'h15,
        GFM_FN_MIC_SHORT = 5'h16
    } gfm_fn_t;

    // Reserved codes: 05, 08, 14 and 17 up to 1F
    localparam logic [31:0] RESERVED_MASK = 32'hFF900120;

endpackage

// file: test/gfm_board_load.sv
// Board model: watches the pin and counts its transitions
`timescale 1ns/1ps
module gfm_board_load (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic pinLevel,
    output logic [15:0] edgeCount,
    output logic boardLevel
);
    // Board sees the pin one cycle late; a change against that copy is one edge
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            edgeCount <= 16'h0000;
            boardLevel <= 1'b0;
        end else begin
            boardLevel <= pinLevel;
            if (boardLevel != pinLevel) begin
                edgeCount <= edgeCount + 16'h0001;
            end
        end
    end
endmodule

// file: test/gfm_pin_mux_tb.sv
// Testbench: APB register access and pin routing checks for the pin multiplexer
`timescale 1ns/1ps
module gfm_pin_mux_tb;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [gfm_pkg::ADDR_W-1:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pstrb = 4'hF;
    logic pready;
    logic pslverr;
    logic gpio2Pin;
    logic [31:0] prdata;
    logic [18:0] src = 19'h00000;
    logic [15:0] edgeCount;
    logic [15:0] e0;
    logic [31:0] rd;
    logic err;
    int n_mismatch = 0;
    int n_checks = 0;
    // Codes in the order of the source vector bits
    logic [4:0] codes [19] = '{5'h00, 5'h02, 5'h03, 5'h04, 5'h06, 5'h07, 5'h09, 5'h0A, 5'h0B, 5'h0C,
        5'h0D, 5'h0E, 5'h0F, 5'h10, 5'h11, 5'h12, 5'h13, 5'h15, 5'h16};

    gfm_pin_mux dut (
        .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .clockOutput(src[0]), .serialDataOut(src[1]), .irqRequest(src[2]), .tempShutdown(src[3]),
        .secondPllLock(src[4]), .thirdPllLock(src[5]), .freqLockedLoopLock(src[6]),
        .rangeCtrlActivity(src[7]), .writeSeqDone(src[8]), .levelNoiseGate(src[9]),
        .levelPeakOverload(src[10]), .levelSaturation(src[11]), .levelThreshold(src[12]),
        .levelLock(src[13]), .fifoError(src[14]), .outputClock(src[15]), .micClock(src[16]),
        .micDetect(src[17]), .micShort(src[18]), .gpio2Pin(gpio2Pin)
    );

    gfm_board_load board (
        .clock(clock), .rst_n(rst_n), .pinLevel(gpio2Pin), .edgeCount(edgeCount), .boardLevel()
    );

    // Free running system clock
    initial begin
        forever #2 clock = ~clock;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Change sources on an edge, then let two edges pass so the pin settles
    task automatic drive_src(input logic [18:0] v);
        @(posedge clock);
        src <= v;
        repeat (2) @(posedge clock);
        #1;
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        report_and_stop;
    end

    initial begin
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        // Level bit masked out: its readback carries no meaning
        apb(1'b0, gfm_pkg::CTRL_ADDR, 32'h00000000, rd, err);
        check(rd & 32'h0000041F, 32'h00000000);
        drive_src(19'h00001);
        check(gpio2Pin, 1'b1);
        $display("test reset done");
        // Only documented codes are programmed here
        for (int inv = 0; inv < 2; inv++) begin
            for (int i = 0; i < 19; i++) begin
                apb(1'b1, gfm_pkg::CTRL_ADDR, (inv << gfm_pkg::INVERT_BIT) | codes[i], rd, err);
                apb(1'b0, gfm_pkg::CTRL_ADDR, 32'h00000000, rd, err);
                check(rd & 32'h0000041F, (inv << gfm_pkg::INVERT_BIT) | codes[i]);
                drive_src(19'h00001 << i);
                check(gpio2Pin, inv == 0);
                drive_src(~(19'h00001 << i));
                check(gpio2Pin, inv != 0);
            end
        end
        $display("test routing done");
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, gfm_pkg::CTRL_ADDR, ((k >> 1) << 10) | ((k & 1) << 6) | gfm_pkg::GFM_FN_LEVEL, rd, err);
            drive_src((k & 1) ? 19'h00000 : 19'h7FFFF);
            check(gpio2Pin, (k & 1) ^ (k >> 1));
            // Status word mirrors the pin; no reserved code is programmed
            apb(1'b0, gfm_pkg::STATUS_ADDR, 32'h00000000, rd, err);
            check(rd, (k & 1) ^ (k >> 1));
            check(err, 1'b0);
        end
        $display("test level done");
        // Unmapped place: refused, write dropped, control unchanged
        apb(1'b1, 12'h000, 32'hFFFFFFFF, rd, err);
        check(err, 1'b1);
        apb(1'b0, 12'h000, 32'h00000000, rd, err);
        check(err, 1'b1);
        check(rd, 32'h00000000);
        // Status is read only: a write is ignored without an error
        apb(1'b1, gfm_pkg::STATUS_ADDR, 32'hFFFFFFFF, rd, err);
        check(err, 1'b0);
        apb(1'b0, gfm_pkg::CTRL_ADDR, 32'h00000000, rd, err);
        check(rd & 32'h0000041F, 32'h00000401);
        $display("test unmapped done");
        // Clock output on code 00h, toggled well below half the system rate
        apb(1'b1, gfm_pkg::CTRL_ADDR, 32'h00000000, rd, err);
        drive_src(19'h00000);
        e0 = edgeCount;
        repeat (8) begin
            @(posedge clock);
            src[0] <= ~src[0];
            repeat (2) @(posedge clock);
        end
        repeat (3) @(posedge clock);
        check(edgeCount - e0, 16'h0008);
        $display("test clock done");
        // Mid-run reset returns the control word to its reset value
        apb(1'b1, gfm_pkg::CTRL_ADDR, 32'h00000416, rd, err);
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        apb(1'b0, gfm_pkg::CTRL_ADDR, 32'h00000000, rd, err);
        check(rd & 32'h0000041F, 32'h00000000);
        $display("test second reset done");
        report_and_stop;
    end
endmodule
